// >>> rtl/psl_map.svh
`ifndef PSL_MAP_SVH
`define PSL_MAP_SVH
// APB register byte offsets
`define PSL_REG_CTRL 12'h000
`define PSL_REG_BF_DLY 12'h004
`define PSL_REG_OP_CFG 12'h008
`define PSL_REG_OP_DLY 12'h00C
`define PSL_REG_SG_DLY 12'h010
`define PSL_REG_TH_CFG 12'h014
`define PSL_REG_TH_LVL 12'h018
`define PSL_REG_STATUS 12'h01C
`define PSL_REG_THETA 12'h020
`define PSL_REG_SEQ 12'h024
// Control bit positions
`define PSL_CTL_OP_EN 0
`define PSL_CTL_SG_EN 1
`define PSL_CTL_BRK_POL 2
`define PSL_CTL_EXT_CFG 3
`define PSL_CTL_MINLOAD 4
// Reset values
`define PSL_CTRL_RST 32'h0000_0000
`define PSL_DLY_RST 32'h0000_0064
`define PSL_TH_CFG_RST 32'h0000_0004
// Tick timing: 1 us tick at 125 MHz
`define PSL_CLK_MHZ 125
`define PSL_TICK_NS 1000
`define PSL_TICK_CYC ((`PSL_TICK_NS * `PSL_CLK_MHZ) / 1000)
// Current thresholds in mA
`define PSL_OP_MIN_MA 100
`define PSL_COOL_MA 50
`endif

// >>> rtl/psl_pkg.sv
package psl_pkg;
    // Breaker failure sequence states
    typedef enum logic [1:0] {
        PSL_BF_IDLE,
        PSL_BF_TIMING,
        PSL_BF_FAILED
    } psl_bf_state_t;
    // Current magnitude in mA
    typedef logic [15:0] psl_cur_t;
endpackage

// >>> rtl/psl_supervision.sv
`timescale 1ns/1ps
`include "psl_map.svh"
module psl_supervision #(
    parameter int TW = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Pins: status contacts, synchronised here
    input wire logic breaker_contact_i,
    input wire logic external_trip_in_i,
    // Protection data from the same clock domain
    input wire logic internal_trip_i,
    input wire logic [7:0] pickup_any_i,
    input wire logic oc_pickup_any_i,
    input wire logic ground_toc_pickup_i,
    input wire logic sens_ground_raw_i,
    input wire psl_pkg::psl_cur_t i_pos_i,
    input wire psl_pkg::psl_cur_t i_neg_i,
    input wire psl_pkg::psl_cur_t i_phase_max_i,
    input wire logic [31:0] theta_restore_i,
    input wire logic theta_restore_valid_i,
    // Trip and indication outputs
    output logic bf_initiate_o,
    output logic current_present_o,
    output logic bf_output_o,
    output logic open_phase_pickup_o,
    output logic open_phase_trip_o,
    output logic sens_ground_pickup_o,
    output logic sens_ground_trip_o,
    output logic thermal_trip_o,
    output logic thermal_alarm_o,
    output logic breaker_open_o,
    output logic [31:0] theta_o
);
    import psl_pkg::*;

    // Saturating timer step
    function automatic logic [TW-1:0] tstep(input logic [TW-1:0] t, input logic run,
                                            input logic tk);
        if (!run) begin
            tstep = '0;
        end else if (tk && t != {TW{1'b1}}) begin
            tstep = t + 1'b1;
        end else begin
            tstep = t;
        end
    endfunction

    // Configuration registers
    logic [31:0] ctrl;
    logic [31:0] bf_dly;
    logic [31:0] op_ratio; // Q8 ratio of negative to positive
    logic [31:0] op_dly;
    logic [31:0] sg_dly;
    logic [31:0] th_cfg; // [7:0] heat shift, [15:8] cool shift, [31:16] minload
    logic [31:0] th_trip_lvl; // Theta of steady maximum current
    logic [31:0] th_alarm_lvl;
    // Synchronisers
    logic brk_m, brk_s, ext_m, ext_s;
    // Tick generator
    logic [7:0] tick_cnt;
    logic tick;
    // Timers and state
    logic [TW-1:0] bf_delay_timer, open_phase_delay, sens_ground_delay;
    psl_bf_state_t bf_state;
    logic [31:0] theta;
    // Combinational terms
    logic external_trip, bf_init, cur_present, brk_open, op_enable, op_pick, sg_pick;
    logic [31:0] i_sq;
    logic [7:0] shft;

    // Two-flop synchronisers for contact pins
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            brk_m <= 1'b0;
            brk_s <= 1'b0;
            ext_m <= 1'b0;
            ext_s <= 1'b0;
        end else begin
            brk_m <= breaker_contact_i;
            brk_s <= brk_m;
            ext_m <= external_trip_in_i;
            ext_s <= ext_m;
        end
    end

    // Periodic processing tick
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            tick_cnt <= 8'h00;
            tick <= 1'b0;
        end else if (tick_cnt == 8'(`PSL_TICK_CYC - 1)) begin
            tick_cnt <= 8'h00;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 8'h01;
            tick <= 1'b0;
        end
    end

    // Decisions from inputs and settings
    always_comb begin
        // External trip only if a contact is assigned
        external_trip = ctrl[`PSL_CTL_EXT_CFG] & ext_s;
        bf_init = internal_trip_i | external_trip;
        cur_present = |pickup_any_i;
        // Polarity 0: contact closed means open breaker
        brk_open = ctrl[`PSL_CTL_BRK_POL] ? ~brk_s : brk_s;
        op_enable = ctrl[`PSL_CTL_OP_EN] && !brk_open
                    && (i_pos_i >= 16'(`PSL_OP_MIN_MA))
                    && !oc_pickup_any_i;
        if (ctrl[`PSL_CTL_MINLOAD] && i_pos_i < th_cfg[31:16]) begin
            op_enable = 1'b0;
        end
        // Ratio neg/pos > setting, cross multiplied
        // Full 32-bit product so large positive currents cannot wrap
        op_pick = op_enable
                  && ({8'h00, i_neg_i, 8'h00}
                      > (32'(i_pos_i) * {16'h0000, op_ratio[15:0]}));
        sg_pick = ctrl[`PSL_CTL_SG_EN] && !ground_toc_pickup_i
                  && sens_ground_raw_i;
        i_sq = 32'(i_phase_max_i) * 32'(i_phase_max_i);
        // Heating by default, cooling below threshold
        shft = (i_phase_max_i < 16'(`PSL_COOL_MA)) ? th_cfg[15:8] : th_cfg[7:0];
    end

    // Breaker failure sequence
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            bf_state <= PSL_BF_IDLE;
            bf_delay_timer <= '0;
            bf_output_o <= 1'b0;
        end else begin
            case (bf_state)
                PSL_BF_IDLE: begin
                    bf_delay_timer <= '0;
                    bf_output_o <= 1'b0;
                    if (bf_init && cur_present) begin
                        bf_state <= PSL_BF_TIMING;
                    end
                end
                PSL_BF_TIMING: begin
                    if (!(bf_init && cur_present)) begin
                        bf_state <= PSL_BF_IDLE;
                        bf_delay_timer <= '0;
                    end else if (bf_delay_timer >= TW'(bf_dly)) begin
                        bf_state <= PSL_BF_FAILED;
                        bf_output_o <= 1'b1;
                    end else begin
                        bf_delay_timer <= tstep(bf_delay_timer, 1'b1, tick);
                    end
                end
                PSL_BF_FAILED: begin
                    if (!(bf_init && cur_present)) begin
                        bf_state <= PSL_BF_IDLE;
                        bf_output_o <= 1'b0;
                        bf_delay_timer <= '0;
                    end
                end
                default: begin
                    bf_state <= PSL_BF_IDLE;
                end
            endcase
        end
    end

    // Open phase and sensitive ground timers
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            open_phase_delay <= '0;
            sens_ground_delay <= '0;
            open_phase_trip_o <= 1'b0;
            sens_ground_trip_o <= 1'b0;
        end else begin
            open_phase_delay <= tstep(open_phase_delay, op_pick, tick);
            sens_ground_delay <= tstep(sens_ground_delay, sg_pick, tick);
            open_phase_trip_o <= op_pick && open_phase_delay >= TW'(op_dly);
            sens_ground_trip_o <= sg_pick && sens_ground_delay >= TW'(sg_dly);
        end
    end

    // Thermal image: theta += (I^2 - theta) >> shift each tick
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            theta <= 32'h0000_0000;
        end else if (theta_restore_valid_i) begin
            theta <= theta_restore_i;
        end else if (tick) begin
            if (i_sq >= theta) begin
                theta <= theta + ((i_sq - theta) >> shft);
            end else begin
                theta <= theta - ((theta - i_sq) >> shft);
            end
        end
    end

    // Registered indications
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            bf_initiate_o <= 1'b0;
            current_present_o <= 1'b0;
            open_phase_pickup_o <= 1'b0;
            sens_ground_pickup_o <= 1'b0;
            thermal_trip_o <= 1'b0;
            thermal_alarm_o <= 1'b0;
            breaker_open_o <= 1'b0;
            theta_o <= 32'h0000_0000;
        end else begin
            bf_initiate_o <= bf_init;
            current_present_o <= cur_present;
            open_phase_pickup_o <= op_pick;
            sens_ground_pickup_o <= sg_pick;
            thermal_trip_o <= theta >= th_trip_lvl;
            thermal_alarm_o <= theta >= th_alarm_lvl;
            breaker_open_o <= brk_open;
            theta_o <= theta;
        end
    end

    // APB writes, zero wait state
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl <= `PSL_CTRL_RST;
            bf_dly <= `PSL_DLY_RST;
            op_ratio <= 32'h0000_0040;
            op_dly <= `PSL_DLY_RST;
            sg_dly <= `PSL_DLY_RST;
            th_cfg <= `PSL_TH_CFG_RST;
            th_trip_lvl <= 32'hFFFF_FFFF;
            th_alarm_lvl <= 32'hFFFF_FFFF;
        end else if (psel_i && penable_i && pwrite_i) begin
            case (paddr_i)
                `PSL_REG_CTRL: ctrl <= {27'h000_0000, pwdata_i[4:0]};
                `PSL_REG_BF_DLY: bf_dly <= pwdata_i;
                `PSL_REG_OP_CFG: op_ratio <= {16'h0000, pwdata_i[15:0]};
                `PSL_REG_OP_DLY: op_dly <= pwdata_i;
                `PSL_REG_SG_DLY: sg_dly <= pwdata_i;
                `PSL_REG_TH_CFG: th_cfg <= pwdata_i;
                `PSL_REG_TH_LVL: th_trip_lvl <= pwdata_i;
                `PSL_REG_THETA: th_alarm_lvl <= pwdata_i;
                default: begin
                end
            endcase
        end
    end

    // APB read data and response
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            if (psel_i && !penable_i) begin
                case (paddr_i)
                    `PSL_REG_CTRL: prdata_o <= ctrl;
                    `PSL_REG_BF_DLY: prdata_o <= bf_dly;
                    `PSL_REG_OP_CFG: prdata_o <= op_ratio;
                    `PSL_REG_OP_DLY: prdata_o <= op_dly;
                    `PSL_REG_SG_DLY: prdata_o <= sg_dly;
                    `PSL_REG_TH_CFG: prdata_o <= th_cfg;
                    `PSL_REG_TH_LVL: prdata_o <= th_trip_lvl;
                    `PSL_REG_THETA: prdata_o <= th_alarm_lvl;
                    `PSL_REG_STATUS: prdata_o <= {21'h00_0000, brk_open, thermal_alarm_o,
                        thermal_trip_o, sens_ground_trip_o, sens_ground_pickup_o,
                        open_phase_trip_o, open_phase_pickup_o, bf_output_o,
                        current_present_o, bf_initiate_o};
                    `PSL_REG_SEQ: prdata_o <= {i_neg_i, i_pos_i};
                    default: pslverr_o <= 1'b1;
                endcase
            end
        end
    end
endmodule

// >>> bench/psl_sup_chk_asserts.sv
`timescale 1ns/1ps
module psl_sup_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Causes
    input wire logic internal_trip_i,
    input wire logic [7:0] pickup_any_i,
    input wire logic oc_pickup_any_i,
    input wire logic ground_toc_pickup_i,
    input wire logic sens_ground_raw_i,
    input wire psl_pkg::psl_cur_t i_pos_i,
    // Outputs watched
    input wire logic bf_initiate_o,
    input wire logic current_present_o,
    input wire logic bf_output_o,
    input wire logic open_phase_pickup_o,
    input wire logic open_phase_trip_o,
    input wire logic sens_ground_pickup_o,
    input wire logic sens_ground_trip_o,
    input wire logic thermal_trip_o
);
    import psl_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_init; internal_trip_i |=> bf_initiate_o; endproperty
    a_init: assert property (p_init) else $error("initiate missing");
    property p_cin; (|pickup_any_i) |=> current_present_o; endproperty
    a_cin: assert property (p_cin) else $error("current flag missing");
    property p_cfast; !(|pickup_any_i) |=> !current_present_o; endproperty
    a_cfast: assert property (p_cfast) else $error("current flag slow");
    property p_bfclr; !(|pickup_any_i) [*3] |=> !bf_output_o; endproperty
    a_bfclr: assert property (p_bfclr) else $error("failure output held");
    property p_opoc; oc_pickup_any_i [*3] |=> !open_phase_pickup_o && !open_phase_trip_o; endproperty
    a_opoc: assert property (p_opoc) else $error("open phase not blocked");
    property p_oplow; (i_pos_i < 16'h0064) [*3] |=> !open_phase_pickup_o; endproperty
    a_oplow: assert property (p_oplow) else $error("open phase at low current");
    property p_optrip; $rose(open_phase_trip_o) |-> $past(open_phase_pickup_o); endproperty
    a_optrip: assert property (p_optrip) else $error("open trip unpicked");
    property p_sgpick; sens_ground_pickup_o |-> $past(sens_ground_raw_i); endproperty
    a_sgpick: assert property (p_sgpick) else $error("ground pickup uncaused");
    property p_sgtoc; ground_toc_pickup_i [*3] |=> !sens_ground_pickup_o && !sens_ground_trip_o;
    endproperty
    a_sgtoc: assert property (p_sgtoc) else $error("ground not blocked");
    property p_rst;
        disable iff (1'b0) !rst_b_i |=> !bf_output_o && !thermal_trip_o && !sens_ground_trip_o;
    endproperty
    a_rst: assert property (p_rst) else $error("trip out of reset");
endmodule
bind psl_supervision psl_sup_chk i_psl_sup_chk (.clk_i, .rst_b_i, .internal_trip_i,
    .pickup_any_i, .oc_pickup_any_i, .ground_toc_pickup_i, .sens_ground_raw_i, .i_pos_i,
    .bf_initiate_o, .current_present_o, .bf_output_o, .open_phase_pickup_o,
    .open_phase_trip_o, .sens_ground_pickup_o, .sens_ground_trip_o, .thermal_trip_o);

// >>> bench/psl_field.sv
`timescale 1ns/1ps
module psl_field (
    // Clock
    input wire logic clk_i,
    // Bench commands
    input wire logic brk_open_i,
    input wire logic ext_trip_i,
    // Status contact pins
    output logic breaker_contact_o,
    output logic external_trip_o
);
    // Contact wired to close while the breaker is open
    always_ff @(posedge clk_i) begin
        breaker_contact_o <= brk_open_i;
        external_trip_o <= ext_trip_i;
    end
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
`include "psl_map.svh"
module tb;
    import psl_pkg::*;
    // Bus and field side
    logic clk_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rdata, theta_restore_i = 32'h0, theta_o;
    logic pready_o, pslverr_o, brk_open = 1'b0, ext_cmd = 1'b0;
    logic breaker_contact_i, external_trip_in_i, internal_trip_i = 1'b0, oc_pickup_any_i = 1'b0;
    logic ground_toc_pickup_i = 1'b0, sens_ground_raw_i = 1'b0, theta_restore_valid_i = 1'b0;
    logic [7:0] pickup_any_i = 8'h00;
    psl_cur_t i_pos_i = 16'h0000, i_neg_i = 16'h0000, i_phase_max_i = 16'h0000;
    logic bf_initiate_o, current_present_o, bf_output_o, open_phase_pickup_o, open_phase_trip_o;
    logic sens_ground_pickup_o, sens_ground_trip_o, thermal_trip_o, thermal_alarm_o, breaker_open_o;
    int num_errors = 0, checks_done = 0;
    psl_supervision i_psl_supervision (.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .breaker_contact_i,
        .external_trip_in_i, .internal_trip_i, .pickup_any_i, .oc_pickup_any_i,
        .ground_toc_pickup_i, .sens_ground_raw_i, .i_pos_i, .i_neg_i, .i_phase_max_i,
        .theta_restore_i, .theta_restore_valid_i, .bf_initiate_o, .current_present_o,
        .bf_output_o, .open_phase_pickup_o, .open_phase_trip_o, .sens_ground_pickup_o,
        .sens_ground_trip_o, .thermal_trip_o, .thermal_alarm_o, .breaker_open_o, .theta_o);
    psl_field i_psl_field (.clk_i, .brk_open_i(brk_open), .ext_trip_i(ext_cmd),
        .breaker_contact_o(breaker_contact_i), .external_trip_o(external_trip_in_i));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Whole ticks plus slack for output latency
    task automatic tk(input int n);
        cyc(n * `PSL_TICK_CYC + 4);
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer, held until pready is sampled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rdata = prdata_o;
        chk("pready", 32'(pready_o), 32'h1);
        chk("pslverr", 32'(pslverr_o), 32'(a > 12'h024));
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #400_000;
        num_errors++;
        stop_test();
    end
    initial begin
        cyc(6);
        rst_b_i <= 1'b1;
        apb(0, `PSL_REG_CTRL, 0);
        chk("ctrl", rdata, `PSL_CTRL_RST);
        apb(0, `PSL_REG_BF_DLY, 0);
        chk("bf_dly", rdata, `PSL_DLY_RST);
        apb(0, `PSL_REG_TH_CFG, 0);
        chk("th_cfg", rdata, `PSL_TH_CFG_RST);
        apb(0, 12'h0FC, 0);
        chk("unmapped", rdata, 32'h0);
        $display("registers done");
        apb(1, `PSL_REG_BF_DLY, 32'h0000_0003);
        ext_cmd <= 1'b1;
        cyc(10);
        chk("ext_off", 32'(bf_initiate_o), 32'h0);
        apb(1, `PSL_REG_CTRL, 32'h0000_0008);
        cyc(10);
        chk("ext_on", 32'(bf_initiate_o), 32'h1);
        ext_cmd <= 1'b0;
        internal_trip_i <= 1'b1;
        pickup_any_i <= 8'h01;
        tk(5);
        chk("c_in", 32'(current_present_o), 32'h1);
        chk("bf_out", 32'(bf_output_o), 32'h1);
        pickup_any_i <= 8'h00;
        cyc(5);
        chk("bf_clr", 32'(bf_output_o), 32'h0);
        pickup_any_i <= 8'h80;
        cyc(2 * `PSL_TICK_CYC);
        internal_trip_i <= 1'b0;
        cyc(10);
        internal_trip_i <= 1'b1;
        cyc(`PSL_TICK_CYC + 5);
        chk("bf_restart", 32'(bf_output_o), 32'h0);
        internal_trip_i <= 1'b0;
        pickup_any_i <= 8'h00;
        $display("breaker failure done");
        apb(1, `PSL_REG_CTRL, 32'h0000_0001);
        apb(1, `PSL_REG_OP_CFG, 32'h0000_0040);
        apb(1, `PSL_REG_OP_DLY, 32'h0000_0002);
        i_pos_i <= 16'h03E8;
        i_neg_i <= 16'h012C;
        cyc(6);
        chk("brk_closed", 32'(breaker_open_o), 32'h0);
        chk("op_pick", 32'(open_phase_pickup_o), 32'h1);
        chk("op_early", 32'(open_phase_trip_o), 32'h0);
        tk(3);
        chk("op_trip", 32'(open_phase_trip_o), 32'h1);
        for (int k = 0; k < 3; k++) begin
            oc_pickup_any_i <= (k == 0);
            i_pos_i <= (k == 1) ? 16'h005A : 16'h03E8;
            brk_open <= (k == 2);
            cyc(10);
            chk("op_off", 32'(open_phase_pickup_o), 32'h0);
        end
        chk("brk_open", 32'(breaker_open_o), 32'h1);
        apb(1, `PSL_REG_CTRL, 32'h0000_0005);
        cyc(10);
        chk("brk_pol", 32'(breaker_open_o), 32'h0);
        chk("op_back", 32'(open_phase_pickup_o), 32'h1);
        apb(1, `PSL_REG_TH_CFG, 32'h07D0_0302);
        apb(1, `PSL_REG_CTRL, 32'h0000_0015);
        cyc(10);
        chk("op_minload", 32'(open_phase_pickup_o), 32'h0);
        i_pos_i <= 16'h0BB8;
        i_neg_i <= 16'h03E8;
        cyc(10);
        chk("op_load", 32'(open_phase_pickup_o), 32'h1);
        i_neg_i <= 16'h02BC;
        cyc(10);
        chk("op_ratio_hi", 32'(open_phase_pickup_o), 32'h0);
        i_neg_i <= 16'h03E8;
        apb(1, `PSL_REG_CTRL, 32'h0000_0000);
        apb(0, `PSL_REG_SEQ, 0);
        chk("seq", rdata, 32'h03E8_0BB8);
        $display("open phase done");
        apb(1, `PSL_REG_CTRL, 32'h0000_0002);
        apb(1, `PSL_REG_SG_DLY, 32'h0000_0002);
        sens_ground_raw_i <= 1'b1;
        cyc(5);
        chk("sg_pick", 32'(sens_ground_pickup_o), 32'h1);
        chk("sg_early", 32'(sens_ground_trip_o), 32'h0);
        tk(3);
        chk("sg_trip", 32'(sens_ground_trip_o), 32'h1);
        ground_toc_pickup_i <= 1'b1;
        cyc(5);
        chk("sg_toc", 32'(sens_ground_pickup_o), 32'h0);
        ground_toc_pickup_i <= 1'b0;
        apb(1, `PSL_REG_CTRL, 32'h0000_0000);
        cyc(5);
        chk("sg_dis", 32'(sens_ground_pickup_o), 32'h0);
        sens_ground_raw_i <= 1'b0;
        $display("sensitive ground done");
        apb(1, `PSL_REG_TH_LVL, 32'h000D_BBA0);
        apb(1, `PSL_REG_THETA, 32'h0007_A120);
        apb(0, `PSL_REG_THETA, 0);
        chk("alarm_lvl", rdata, 32'h0007_A120);
        i_phase_max_i <= 16'h03E8;
        tk(1);
        chk("alarm_low", 32'(thermal_alarm_o), 32'h0);
        tk(2);
        chk("alarm_on", 32'(thermal_alarm_o), 32'h1);
        chk("trip_low", 32'(thermal_trip_o), 32'h0);
        tk(12);
        chk("trip_on", 32'(thermal_trip_o), 32'h1);
        i_phase_max_i <= 16'h0028;
        tk(3);
        chk("cool_slow", 32'(thermal_alarm_o), 32'h1);
        tk(12);
        chk("cool_off", 32'(thermal_alarm_o), 32'h0);
        rst_b_i <= 1'b0;
        cyc(2);
        rst_b_i <= 1'b1;
        cyc(1);
        chk("theta_rst", theta_o, 32'h0);
        theta_restore_i <= 32'h0000_0640;
        theta_restore_valid_i <= 1'b1;
        cyc(1);
        theta_restore_valid_i <= 1'b0;
        cyc(3);
        chk("theta_keep", theta_o, 32'h0000_0640);
        $display("thermal done");
        stop_test();
    end
endmodule
